// ### src/gif_global_irq.sv
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - combined tx flag set when any tx buffer has flag and enable both high
// - combined tx flag ignores writes; clears when buffer flags or enables clear
// - module enable gates module line from module summary flag
// - protocol enable gates protocol line from protocol summary flag
// - host error enable gates host error line from its summary flag
// - wakeup enable gates wakeup line from wakeup flag
// - queue B enable gates queue B line from queue B not-empty flag
// - queue A enable gates queue A line from queue A not-empty flag
// - rx buffer enable gates rx buffer line from combined rx flag
// - tx buffer enable gates tx buffer line from combined tx flag
// - module summary flag set when any other flag and its enable are set
// - combined rx flag not host clearable; follows buffer flags and enables
// - writing one to queue A flag advances or wraps queue A read index when queue A is not empty
// - protocol summary set when any protocol flag meets its enable
module gif_global_irq (
  input  wire logic                              sys_clk,
  input  wire logic                              rstn,
  input  wire logic                              clkEn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [11:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [gif_pkg::NUM_BUFFERS-1:0]   perBufferIrqFlag,
  input  wire logic [gif_pkg::NUM_BUFFERS-1:0]   perBufferIrqEnable,
  input  wire logic [gif_pkg::NUM_BUFFERS-1:0]   bufferDirectionSelect,
  input  wire logic [gif_pkg::NUM_PROT_FLAGS-1:0] protocolFlags,
  input  wire logic [gif_pkg::NUM_PROT_FLAGS-1:0] protocolEnables,
  input  wire logic                              hostInterfaceErrorFlag,
  input  wire logic                              wakeupIrqFlag,
  input  wire logic                              rxQueueBNonemptyFlag,
  input  wire logic [gif_pkg::QUEUE_IDX_W-1:0]   rxQueueAFill,
  input  wire logic [gif_pkg::QUEUE_IDX_W-1:0]   rxQueueADepth,
  output logic [gif_pkg::QUEUE_IDX_W-1:0]        rxQueueAReadIndex,
  output logic                                   rxQueueAPop,
  output logic                                   moduleIrq,
  output logic                                   protocolIrq,
  output logic                                   hostErrorIrq,
  output logic                                   wakeupIrq,
  output logic                                   rxQueueBIrq,
  output logic                                   rxQueueAIrq,
  output logic                                   rxBufferIrq,
  output logic                                   txBufferIrq,
  output logic                                   irq
);
  import gif_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  // setup and access phases of one transfer
  wire logic apbSetup  = psel & ~penable;
  wire logic apbAccess = psel & penable & clkEn;
  wire logic apbWrite  = apbAccess & pwrite;

  wire logic selFlag   = (paddr == GIF_FLAG_ENABLE_OFFS);
  wire logic selStat   = (paddr == GIF_IRQ_STATUS_OFFS);
  wire logic selMask   = (paddr == GIF_IRQ_MASK_OFFS);
  wire logic selQueue  = (paddr == GIF_QUEUE_A_OFFS);
  wire logic selAny    = selFlag | selStat | selMask | selQueue;

  // writes land only at the access edge, with the address decoded then
  wire logic wrFlag    = apbWrite & selFlag;
  wire logic wrStat    = apbWrite & selStat;
  wire logic wrMask    = apbWrite & selMask;

  // read data is caught in the setup cycle, which keeps the mux out of the access path
  wire logic rdSetup   = apbSetup & ~pwrite;

  //////////////////////////////////////////////////////////////////////////////
  // state and next-state nets
  logic [7:0]                  enable_reg;
  wire logic [7:0]             enable_next;
  logic [7:0]                  irqStatus_reg;
  wire logic [7:0]             irqStatus_next;
  logic [7:0]                  irqMask_reg;
  wire logic [7:0]             irqMask_next;
  logic [QUEUE_IDX_W-1:0]      qaIndex_reg;
  wire logic [QUEUE_IDX_W-1:0] qaIndex_next;
  logic                        qaPop_reg;
  logic [7:0]                  lines_reg;
  wire logic [7:0]             linesNext;
  logic                        irq_reg;
  wire logic                   irq_next;
  logic [31:0]                 prdata_reg;
  wire logic [31:0]            prdata_next;
  logic                        pslverr_reg;
  wire logic                   pslverr_next;

  //////////////////////////////////////////////////////////////////////////////
  // buffer, protocol and queue flags
  wire logic [NUM_BUFFERS-1:0] txHit = perBufferIrqFlag & perBufferIrqEnable & bufferDirectionSelect;
  wire logic [NUM_BUFFERS-1:0] rxHit = perBufferIrqFlag & perBufferIrqEnable & ~bufferDirectionSelect;
  // both combined buffer flags are pure functions of the buffers, so host writes cannot touch them
  wire logic txFlag   = |txHit;
  wire logic rxFlag   = |rxHit;

  // protocol summary: any individual protocol flag met by its own enable
  wire logic protFlag = |(protocolFlags & protocolEnables);

  // queue A flag follows the fill level, so it drops by itself once a pop empties the queue
  wire logic qaFlag   = (rxQueueAFill != '0);

  //////////////////////////////////////////////////////////////////////////////
  // flag vector indexed like the enables: bit i pairs with enable i
  wire logic [7:0] flagVec;
  // the module line has no flag of its own; the summary below feeds it
  assign flagVec[7] = 1'b0;
  assign flagVec[6] = protFlag;
  assign flagVec[5] = hostInterfaceErrorFlag;
  assign flagVec[4] = wakeupIrqFlag;
  assign flagVec[3] = rxQueueBNonemptyFlag;
  assign flagVec[2] = qaFlag;
  assign flagVec[1] = rxFlag;
  assign flagVec[0] = txFlag;

  wire logic [7:0] gated   = flagVec & enable_reg;
  // module summary looks at the seven non-module lines
  wire logic modFlag       = |gated[6:0];

  //////////////////////////////////////////////////////////////////////////////
  // per-line logic: output level and sticky status bit
  // enable bit 7 gates the module line; the others gate their own flag
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      if (gi == ENABLE_MSB) begin : g_mod
        assign linesNext[gi] = modFlag & enable_reg[gi];
      end else begin : g_oth
        assign linesNext[gi] = gated[gi];
      end

      // a rising line sets its status bit; the set beats a write-one clear in the same cycle
      assign irqStatus_next[gi] = (linesNext[gi] & ~lines_reg[gi]) |
                                  (irqStatus_reg[gi] & ~(wrStat & pwdata[gi]));

      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          lines_reg[gi]     <= LINES_RESET[gi];
          irqStatus_reg[gi] <= IRQ_STATUS_RESET[gi];
        end else if (clkEn) begin
          lines_reg[gi]     <= linesNext[gi];
          irqStatus_reg[gi] <= irqStatus_next[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // register view of the flag/enable register
  // the combined flags are images of their sources, so a write to them has no effect
  wire logic [15:0] flagEnableView;
  assign flagEnableView[MOD_FLAG_BIT]   = modFlag;
  assign flagEnableView[PROT_FLAG_BIT]  = protFlag;
  assign flagEnableView[HIE_FLAG_BIT]   = hostInterfaceErrorFlag;
  assign flagEnableView[WAKE_FLAG_BIT]  = wakeupIrqFlag;
  assign flagEnableView[QB_FLAG_BIT]    = rxQueueBNonemptyFlag;
  assign flagEnableView[QA_FLAG_BIT]    = qaFlag;
  assign flagEnableView[RXB_FLAG_BIT]   = rxFlag;
  assign flagEnableView[TXB_FLAG_BIT]   = txFlag;
  assign flagEnableView[ENABLE_MSB:0]   = enable_reg;

  // one word per register, upper bits read as zero
  wire logic [31:0] rdFlagWord  = {16'h0000, flagEnableView};
  wire logic [31:0] rdStatWord  = {24'h00_0000, irqStatus_reg};
  wire logic [31:0] rdMaskWord  = {24'h00_0000, irqMask_reg};
  wire logic [31:0] rdQueueWord = {24'h00_0000, qaIndex_reg};

  // unmapped addresses fall through to zero
  wire logic [31:0] readMux = selFlag  ? rdFlagWord :
                              selStat  ? rdStatWord :
                              selMask  ? rdMaskWord :
                              selQueue ? rdQueueWord : 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////
  // queue A pop
  // writing one to the queue A flag pops one entry; an empty queue ignores the write
  wire logic qaPopReq = wrFlag & pwdata[QA_FLAG_BIT] & qaFlag;
  wire logic [QUEUE_IDX_W-1:0] qaInc = qaIndex_reg + 8'h01;
  // the wrap point is the depth the queue reports, so a smaller depth still wraps
  wire logic qaWrap   = (qaInc >= rxQueueADepth);

  //////////////////////////////////////////////////////////////////////////////
  // next-state selection
  assign enable_next  = wrFlag ? pwdata[ENABLE_MSB:0] : enable_reg;
  assign irqMask_next = wrMask ? pwdata[7:0] : irqMask_reg;
  assign qaIndex_next = !qaPopReq ? qaIndex_reg :
                        qaWrap    ? QUEUE_IDX_RESET : qaInc;
  // irq looks at next status and mask, so it moves in the same cycle as the status bit
  assign irq_next     = |(irqStatus_next & irqMask_next);
  assign prdata_next  = rdSetup ? readMux : prdata_reg;
  // an unmapped address answers with an error in the access phase; writes there are dropped
  assign pslverr_next = apbSetup & ~selAny;

  //////////////////////////////////////////////////////////////////////////////
  // enables: plain read/write storage
  // the only bits of the flag/enable register that a write stores; a one written to the queue A flag pops instead
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= ENABLE_RESET;
    end else if (clkEn) begin
      enable_reg <= enable_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mask of the sticky status
  // masking hides a status bit from irq but never stops it from being set
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqMask_reg <= IRQ_MASK_RESET;
    end else if (clkEn) begin
      irqMask_reg <= irqMask_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // queue A read index
  // the index only moves on a pop, never on a plain read of the register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      qaIndex_reg <= QUEUE_IDX_RESET;
    end else if (clkEn) begin
      qaIndex_reg <= qaIndex_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pop pulse to the queue
  // one cycle per accepted pop, the cycle after the write lands
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      qaPop_reg <= 1'b0;
    end else if (clkEn) begin
      qaPop_reg <= qaPopReq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // summary interrupt
  // a level: it stays high until software clears or masks every pending bit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else if (clkEn) begin
      irq_reg <= irq_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data
  // held until the next read setup, so a slow master still sees it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (clkEn) begin
      prdata_reg <= prdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // error response
  // loaded in the setup cycle and dropped again at the access edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pslverr_reg <= 1'b0;
    end else if (clkEn) begin
      pslverr_reg <= pslverr_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops except the constant ready
  // bus answer: the access phase always ends in one cycle
  assign prdata            = prdata_reg;
  assign pready            = 1'b1;
  assign pslverr           = pslverr_reg;

  // queue A
  assign rxQueueAReadIndex = qaIndex_reg;
  assign rxQueueAPop       = qaPop_reg;

  // interrupt lines, flag AND enable one edge after their sources
  assign txBufferIrq       = lines_reg[0];
  assign rxBufferIrq       = lines_reg[1];
  assign rxQueueAIrq       = lines_reg[2];
  assign rxQueueBIrq       = lines_reg[3];
  assign wakeupIrq         = lines_reg[4];
  assign hostErrorIrq      = lines_reg[5];
  assign protocolIrq       = lines_reg[6];
  assign moduleIrq         = lines_reg[7];

  // sticky summary
  assign irq               = irq_reg;

endmodule

// ### src/gif_pkg.sv
package gif_pkg;

  // register map (byte addresses on the 32-bit bus)
  localparam logic [11:0] GIF_FLAG_ENABLE_OFFS = 12'h000;
  localparam logic [11:0] GIF_IRQ_STATUS_OFFS  = 12'h004;
  localparam logic [11:0] GIF_IRQ_MASK_OFFS    = 12'h008;
  localparam logic [11:0] GIF_QUEUE_A_OFFS     = 12'h00C;

  // field positions of the flag/enable register
  localparam int MOD_FLAG_BIT     = 15;
  localparam int PROT_FLAG_BIT    = 14;
  localparam int HIE_FLAG_BIT     = 13;
  localparam int WAKE_FLAG_BIT    = 12;
  localparam int QB_FLAG_BIT      = 11;
  localparam int QA_FLAG_BIT      = 10;
  localparam int RXB_FLAG_BIT     = 9;
  localparam int TXB_FLAG_BIT     = 8;
  localparam int ENABLE_MSB       = 7;

  // widths
  localparam int NUM_BUFFERS      = 16;
  localparam int NUM_PROT_FLAGS   = 32;
  localparam int QUEUE_IDX_W      = 8;
  localparam int NUM_LINES        = 8;

  // reset values
  localparam logic [7:0]  ENABLE_RESET     = 8'h00;
  localparam logic [7:0]  IRQ_STATUS_RESET = 8'h00;
  localparam logic [7:0]  IRQ_MASK_RESET   = 8'h00;
  localparam logic [7:0]  LINES_RESET      = 8'h00;
  localparam logic [QUEUE_IDX_W-1:0] QUEUE_IDX_RESET = 8'h00;
  localparam logic [QUEUE_IDX_W-1:0] QUEUE_DEPTH_RESET = 8'h10;

endpackage

// ### tb/gif_global_irq_properties.sv
`timescale 1ns/100ps
module gif_global_irq_properties (
  input wire logic                            sys_clk,
  input wire logic                            rstn,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic [11:0]                     paddr,
  input wire logic                            pready,
  input wire logic                            pslverr,
  input wire logic [gif_pkg::NUM_BUFFERS-1:0] perBufferIrqFlag,
  input wire logic [gif_pkg::NUM_BUFFERS-1:0] perBufferIrqEnable,
  input wire logic [gif_pkg::NUM_BUFFERS-1:0] bufferDirectionSelect,
  input wire logic [gif_pkg::NUM_PROT_FLAGS-1:0] protocolFlags,
  input wire logic [gif_pkg::NUM_PROT_FLAGS-1:0] protocolEnables,
  input wire logic                            protocolIrq,
  input wire logic                            moduleIrq,
  input wire logic                            hostInterfaceErrorFlag,
  input wire logic                            wakeupIrqFlag,
  input wire logic                            rxQueueBNonemptyFlag,
  input wire logic [gif_pkg::QUEUE_IDX_W-1:0] rxQueueAFill,
  input wire logic                            hostErrorIrq,
  input wire logic                            wakeupIrq,
  input wire logic                            rxQueueBIrq,
  input wire logic                            rxQueueAIrq,
  input wire logic                            rxBufferIrq,
  input wire logic                            txBufferIrq
);
  import gif_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire bufHit = |(perBufferIrqFlag & perBufferIrqEnable);
  wire txHit  = |(perBufferIrqFlag & perBufferIrqEnable & bufferDirectionSelect);
  wire rxHit  = |(perBufferIrqFlag & perBufferIrqEnable & ~bufferDirectionSelect);
  wire badAdr = !(paddr inside {GIF_FLAG_ENABLE_OFFS, GIF_IRQ_STATUS_OFFS, GIF_IRQ_MASK_OFFS, GIF_QUEUE_A_OFFS});
  wire protHit = |(protocolFlags & protocolEnables);
  wire otherLines = protocolIrq | hostErrorIrq | wakeupIrq | rxQueueBIrq | rxQueueAIrq | rxBufferIrq | txBufferIrq;
  prot_line_a: assert property (protocolIrq |-> $past(protHit))
    else $error("protocol line high without a protocol event");
  mod_line_a: assert property (moduleIrq |-> otherLines)
    else $error("module line high with no other line high");
  tx_line_a: assert property (txBufferIrq |-> $past(txHit) && $past(bufHit))
    else $error("tx line high without a tx buffer event");
  rx_line_a: assert property (rxBufferIrq |-> $past(rxHit))
    else $error("rx line high without an rx buffer event");
  qa_line_a: assert property (rxQueueAIrq |-> $past(rxQueueAFill) != 8'h00)
    else $error("queue A line high while queue empty");
  qb_line_a: assert property (rxQueueBIrq |-> $past(rxQueueBNonemptyFlag))
    else $error("queue B line high without its flag");
  wake_line_a: assert property (wakeupIrq |-> $past(wakeupIrqFlag))
    else $error("wakeup line high without its flag");
  hie_line_a: assert property (hostErrorIrq |-> $past(hostInterfaceErrorFlag))
    else $error("host error line high without its flag");
  bus_err_a: assert property (psel && !penable |=> pslverr == $past(badAdr))
    else $error("error response does not match address decode");
  bus_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
endmodule
bind gif_global_irq gif_global_irq_properties u_gif_global_irq_properties (.*);

// ### tb/global_irq_flag_enable_tb_top.sv
`timescale 1ns/100ps
module global_irq_flag_enable_tb_top;
  import gif_pkg::*;
  logic        sys_clk = 0, rstn = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, protocolFlags = '0, protocolEnables = '0;
  logic        pready, pslverr, rxQueueAPop, irq, errSeen;
  logic [15:0] perBufferIrqFlag = '0, perBufferIrqEnable = '0, bufferDirectionSelect = 16'h0001;
  logic        hostInterfaceErrorFlag = 0, wakeupIrqFlag = 0, rxQueueBNonemptyFlag = 0;
  logic [7:0]  rxQueueAFill = '0, rxQueueADepth = 8'h04, rxQueueAReadIndex;
  logic        moduleIrq, protocolIrq, hostErrorIrq, wakeupIrq, rxQueueBIrq, rxQueueAIrq, rxBufferIrq, txBufferIrq;
  wire [7:0]   lines = {moduleIrq, protocolIrq, hostErrorIrq, wakeupIrq, rxQueueBIrq, rxQueueAIrq, rxBufferIrq, txBufferIrq};
  int          err_total = 0, num_checks = 0, popCount = 0;
  always @(posedge sys_clk) if (rxQueueAPop === 1'b1) popCount <= popCount + 1;
  gif_global_irq u_gif_global_irq (.*);
  initial forever #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one idle cycle after each transfer keeps psel from being driven twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, '0);
    chk(nm, rd, e);
  endtask
  // lines and sticky status settle within two edges of the write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rc(GIF_FLAG_ENABLE_OFFS, '0, "fe_reset");
    rc(GIF_IRQ_STATUS_OFFS, '0, "status_reset");
    rc(GIF_IRQ_MASK_OFFS, '0, "mask_reset");
    rc(GIF_QUEUE_A_OFFS, '0, "qa_index_reset");
    wr(GIF_FLAG_ENABLE_OFFS, 32'h0000_00A5);
    rc(GIF_FLAG_ENABLE_OFFS, 32'h0000_00A5, "enables_rw");
    perBufferIrqFlag <= 16'h0003;
    perBufferIrqEnable <= 16'h0003;
    protocolFlags <= 32'h0000_0001;
    protocolEnables <= 32'h0000_0001;
    hostInterfaceErrorFlag <= 1'b1;
    wakeupIrqFlag <= 1'b1;
    rxQueueBNonemptyFlag <= 1'b1;
    rxQueueAFill <= 8'h02;
    for (int i = 0; i < 8; i++) begin
      wr(GIF_FLAG_ENABLE_OFFS, 32'h0000_0001 << i);
      chk("lines", lines, (i == 7) ? 32'h0000_0000 : 32'h0000_0001 << i);
    end
    wr(GIF_FLAG_ENABLE_OFFS, 32'h0000_0181);
    chk("lines_module", lines, 32'h0000_0081);
    rc(GIF_FLAG_ENABLE_OFFS, 32'h0000_FF81, "fe_flags");
    perBufferIrqFlag <= '0;
    repeat (2) @(posedge sys_clk);
    chk("lines_tx_clear", lines, '0);
    rc(GIF_FLAG_ENABLE_OFFS, 32'h0000_7C81, "fe_tx_cleared");
    rc(GIF_IRQ_STATUS_OFFS, 32'h0000_00FF, "status_sticky");
    chk("irq_masked", irq, 1'b0);
    wr(GIF_IRQ_MASK_OFFS, 32'h0000_0001);
    chk("irq_unmasked", irq, 1'b1);
    wr(GIF_IRQ_STATUS_OFFS, 32'h0000_00FF);
    chk("irq_cleared", irq, 1'b0);
    rc(GIF_IRQ_STATUS_OFFS, '0, "status_cleared");
    rc(12'h010, '0, "unmapped_data");
    chk("unmapped_err", errSeen, 1'b1);
    clkEn <= 1'b0;
    wr(GIF_IRQ_MASK_OFFS, 32'h0000_00FF);
    clkEn <= 1'b1;
    rc(GIF_IRQ_MASK_OFFS, 32'h0000_0001, "mask_frozen");
    wr(GIF_FLAG_ENABLE_OFFS, 32'h0000_0400);
    rc(GIF_QUEUE_A_OFFS, 32'h0000_0001, "qa_index_pop");
    chk("qa_index_pin", rxQueueAReadIndex, 32'h0000_0001);
    repeat (3) wr(GIF_FLAG_ENABLE_OFFS, 32'h0000_0400);
    rc(GIF_QUEUE_A_OFFS, 32'h0000_0000, "qa_index_wrap");
    rxQueueAFill <= 8'h00;
    wr(GIF_FLAG_ENABLE_OFFS, 32'h0000_0400);
    rc(GIF_QUEUE_A_OFFS, 32'h0000_0000, "qa_pop_empty");
    chk("qa_pops", popCount, 32'h0000_0004);
    complete_run();
  end
  initial begin
    #50us;
    err_total++;
    complete_run();
  end
endmodule
